// ==== bench/far_end.sv ====
`timescale 1ns/1ps
module far_end (
   // Link clock and lines driven by the block
   input  wire logic       link_clk,
   input  wire logic [1:0] txd,
   input  wire logic       tx_clock_out,
   input  wire logic       rx_clock_pin_out,
   input  wire logic       rx_clock_pin_oe,
   // Lines driven by the far end
   output logic [1:0]      rxd,
   output logic            clear_to_send_n,
   output logic            rx_clock_pin_line
);
   logic       ext_clk = 1'b1;
   logic [7:0] burst_sh = 8'h00;
   int         rise_cnt = 0, tx_rise = 0;

   initial rxd = 2'h3;
   initial clear_to_send_n = 1'b1;
   // Far end lets go of the shared pin while the block drives it
   assign rx_clock_pin_line = rx_clock_pin_oe ? rx_clock_pin_out : ext_clk;

   // New data on the falling edge so it is settled at the block's rising edge
   always @(negedge rx_clock_pin_out) begin
      if (rx_clock_pin_oe) begin
         rxd[0] <= burst_sh[7];
         burst_sh <= {burst_sh[6:0], 1'b0};
      end
   end
   always @(posedge rx_clock_pin_out) begin
      if (rx_clock_pin_oe) rise_cnt <= rise_cnt + 1;
   end
   always @(posedge tx_clock_out) tx_rise <= tx_rise + 1;

   task get_async(input int ch, input int n, output logic [11:0] bits, output bit ok);
      int i;
      bits = 12'h000;
      ok = 1'b0;
      for (i = 0; i < 400 && !ok; i++) begin
         @(negedge link_clk);
         ok = (txd[ch] === 1'b0);
      end
      for (i = 0; i < n; i++) begin
         @(negedge link_clk);
         bits[i] = txd[ch];
      end
   endtask

   task get_clocked(output logic [7:0] d, output bit ok);
      int   i;
      int   n;
      logic prev;
      n = 0;
      prev = 1'b1;
      for (i = 0; i < 800 && n < 8; i++) begin
         @(negedge link_clk);
         if (!prev && tx_clock_out) begin
            d = {d[6:0], txd[0]};
            n++;
         end
         prev = tx_clock_out;
      end
      ok = (n == 8);
   endtask

   task send_async(input int ch, input logic [7:0] d);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge link_clk);
         rxd[ch] <= f[i];
      end
      @(posedge link_clk);
   endtask

   // Slow clock so that a write can land between two bits
   task ext_clock(input logic [7:0] d, input int n);
      for (int i = 0; i < n; i++) begin
         repeat (4) @(posedge link_clk);
         ext_clk <= 1'b0;
         rxd[0] <= d[7 - i];
         repeat (4) @(posedge link_clk);
         ext_clk <= 1'b1;
      end
   endtask
endmodule

// ==== bench/serial_mode_control_tb.sv ====
`timescale 1ns/1ps
module serial_mode_control_tb import serial_mode_pkg::*;;
   logic            clk, reset_n, link_clk, mode_wr, mode_bit_wr, mode_ch, mode_bit_val;
   logic            tx_clock_out, clear_to_send_n, rx_clock_pin_line, rx_clock_pin_out;
   logic            rx_clock_pin_oe;
   logic [2:0]      mode_bit_idx;
   logic [7:0]      mode_wr_data, tx_buffer_data;
   logic [1:0][7:0] mode_rd_data, rx_data;
   logic [1:0]      tx_buffer_wr, tx_buffer_full, tx_irq_flag, tx_irq_clear, rx_done, txd, rxd;
   int              bad_count = 0, total_checks = 0, done0 = 0, done1 = 0;

   always #25 clk = ~clk;
   initial begin
      link_clk = 1'b0;
      #3.1;
      forever #6 link_clk = ~link_clk;
   end

   serial_mode_control u_serial_mode_control (
      .clk(clk), .reset_n(reset_n), .link_clk(link_clk), .mode_wr(mode_wr),
      .mode_bit_wr(mode_bit_wr), .mode_ch(mode_ch), .mode_bit_idx(mode_bit_idx),
      .mode_bit_val(mode_bit_val), .mode_wr_data(mode_wr_data),
      .mode_rd_data(mode_rd_data), .tx_buffer_wr(tx_buffer_wr),
      .tx_buffer_data(tx_buffer_data), .tx_buffer_full(tx_buffer_full),
      .tx_irq_flag(tx_irq_flag), .tx_irq_clear(tx_irq_clear), .rx_data(rx_data),
      .rx_done(rx_done), .txd(txd), .rxd(rxd), .tx_clock_out(tx_clock_out),
      .clear_to_send_n(clear_to_send_n), .rx_clock_pin_in(rx_clock_pin_line),
      .rx_clock_pin_out(rx_clock_pin_out), .rx_clock_pin_oe(rx_clock_pin_oe));
   far_end u_far_end (
      .link_clk(link_clk), .txd(txd), .tx_clock_out(tx_clock_out),
      .rx_clock_pin_out(rx_clock_pin_out), .rx_clock_pin_oe(rx_clock_pin_oe),
      .rxd(rxd), .clear_to_send_n(clear_to_send_n),
      .rx_clock_pin_line(rx_clock_pin_line));

   always @(negedge clk) begin
      if (rx_done[0] === 1'b1) done0++;
      if (rx_done[1] === 1'b1) done1++;
   end

   task compare(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task end_sim;
      if (bad_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task fail_wait(input string what);
      compare(what, 12'h001, 12'h000);
      end_sim;
   endtask

   task cycles(input int n);
      repeat (n) @(negedge clk);
   endtask

   task mode_write(input logic ch, input logic [7:0] d);
      @(negedge clk);
      mode_ch = ch;
      mode_wr_data = d;
      mode_wr = 1'b1;
      @(negedge clk);
      mode_wr = 1'b0;
   endtask

   task bit_write(input logic ch, input logic [2:0] idx, input logic v);
      @(negedge clk);
      mode_ch = ch;
      mode_bit_idx = idx;
      mode_bit_val = v;
      mode_bit_wr = 1'b1;
      @(negedge clk);
      mode_bit_wr = 1'b0;
   endtask

   task tx_write(input logic ch, input logic [7:0] d);
      @(negedge clk);
      tx_buffer_data = d;
      tx_buffer_wr[ch] = 1'b1;
      @(negedge clk);
      tx_buffer_wr = 2'h0;
   endtask

   task clear_flag(input logic ch);
      @(negedge clk);
      tx_irq_clear[ch] = 1'b1;
      @(negedge clk);
      tx_irq_clear = 2'h0;
   endtask

   task wait_flag(input logic ch);
      for (int i = 0; i < 200 && tx_irq_flag[ch] !== 1'b1; i++) @(negedge clk);
      if (tx_irq_flag[ch] !== 1'b1) fail_wait("tx flag");
   endtask

   task wait_done(input logic ch, input int n);
      for (int i = 0; i < 400 && (ch ? done1 : done0) < n; i++) @(negedge clk);
      if ((ch ? done1 : done0) < n) fail_wait("rx done");
   endtask

   task t_reset;
      compare("mode regs", 12'h000, {mode_rd_data[1], mode_rd_data[0]});
      compare("flags", 12'h000, {tx_irq_flag, tx_buffer_full});
      compare("lines", 12'h00D, {txd, rx_clock_pin_oe, tx_clock_out});
   endtask

   task t_access;
      mode_write(1, 8'hC5);
      bit_write(1, 3'h7, 1'b0);
      bit_write(1, 3'h1, 1'b1);
      compare("mode ch1", 12'h047, mode_rd_data[1]);
      compare("mode ch0", 12'h000, mode_rd_data[0]);
      // Clear-to-send is low, so only the mode code holds the word
      u_far_end.clear_to_send_n = 1'b0;
      mode_write(1, 8'h80);
      tx_write(1, 8'h11);
      cycles(40);
      compare("ch1 clocked", 12'h001, {tx_irq_flag[1], tx_buffer_full[1]});
      u_far_end.clear_to_send_n = 1'b1;
   endtask

   task automatic t_async_tx;
      logic [7:0]  md [4] = '{8'hB9, 8'hA1, 8'h99, 8'h8D};
      logic [7:0]  dt [4] = '{8'hA5, 8'h35, 8'hFF, 8'h3C};
      int          nb [4] = '{9, 8, 9, 10};
      logic [11:0] ex [4] = '{12'h0A5, 12'h0B5, 12'h0FF, 12'h33C};
      logic [11:0] bits;
      bit          ok;
      mode_write(1, md[0]);
      tx_write(1, dt[0]);
      cycles(40);
      compare("cts held", 12'h001, {tx_irq_flag[1], tx_buffer_full[1]});
      for (int k = 0; k < 4; k++) begin
         if (k > 0) mode_write(1, md[k]);
         fork
            u_far_end.get_async(1, nb[k], bits, ok);
            begin
               if (k == 0) begin
                  @(negedge clk);
                  u_far_end.clear_to_send_n = 1'b0;
               end else tx_write(1, dt[k]);
               wait_flag(1);
            end
         join
         compare("async frame", ex[k], ok ? bits : 12'hEEE);
         compare("buffer empty", 12'h000, tx_buffer_full[1]);
         clear_flag(1);
         cycles(4);
      end
   endtask

   task automatic t_async_rx;
      logic [7:0] md [3] = '{8'h49, 8'h41, 8'h59};
      logic [7:0] sd [3] = '{8'h3C, 8'hBC, 8'hA6};
      logic [7:0] ed [3] = '{8'h3C, 8'h3C, 8'hA6};
      for (int k = 0; k < 3; k++) begin
         mode_write(1, md[k]);
         u_far_end.send_async(1, sd[k]);
         wait_done(1, k + 1);
         compare("async rx", ed[k], rx_data[1]);
      end
   endtask

   task t_clocked_rx;
      mode_write(0, 8'h40);
      u_far_end.ext_clock(8'h96, 8);
      wait_done(0, 1);
      compare("ext rx", 12'h096, rx_data[0]);
      u_far_end.ext_clock(8'h5A, 4);
      mode_write(0, 8'h00);
      u_far_end.ext_clock(8'hA0, 4);
      cycles(10);
      compare("abort", 12'h001, done0[11:0]);
      mode_write(0, 8'h40);
      u_far_end.ext_clock(8'hC3, 8);
      wait_done(0, 2);
      compare("rx after abort", 12'h0C3, rx_data[0]);
   endtask

   task t_burst;
      int r0;
      mode_write(0, 8'h44);
      r0 = u_far_end.rise_cnt;
      u_far_end.burst_sh = 8'h69;
      bit_write(0, 3'h3, 1'b1);
      compare("pin drive", 12'h001, rx_clock_pin_oe);
      for (int i = 0; i < 200 && mode_rd_data[0] !== 8'h44; i++) @(negedge clk);
      compare("trigger clear", 12'h044, mode_rd_data[0]);
      r0 = u_far_end.rise_cnt - r0;
      compare("burst clocks", 12'h008, r0[11:0]);
      wait_done(0, 3);
      compare("burst rx", 12'h069, rx_data[0]);
   endtask

   task t_clocked_tx;
      logic [7:0] d, d2;
      bit         ok, ok2;
      int         r0;
      mode_write(0, 8'h00);
      tx_write(0, 8'hC3);
      cycles(40);
      compare("held", 12'h001, {tx_irq_flag[0], tx_buffer_full[0]});
      fork
         u_far_end.get_clocked(d, ok);
         begin
            mode_write(0, 8'h80);
            wait_flag(0);
            tx_write(0, 8'h5A);
            mode_write(0, 8'h00);
         end
      join
      compare("first word", 12'h0C3, ok ? d : 8'hEE);
      r0 = u_far_end.tx_rise;
      cycles(40);
      r0 = u_far_end.tx_rise - r0;
      compare("pending", 12'h100, {tx_buffer_full[0], r0[7:0]});
      clear_flag(0);
      fork
         begin
            u_far_end.get_clocked(d, ok);
            u_far_end.get_clocked(d2, ok2);
         end
         begin
            mode_write(0, 8'h80);
            wait_flag(0);
            tx_write(0, 8'h7E);
         end
      join
      compare("held word", 12'h05A, ok ? d : 8'hEE);
      compare("next word", 12'h07E, ok2 ? d2 : 8'hEE);
   endtask

   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      {mode_wr, mode_bit_wr, mode_ch, mode_bit_val} = 4'h0;
      mode_bit_idx = 3'h0;
      mode_wr_data = 8'h00;
      tx_buffer_data = 8'h00;
      tx_buffer_wr = 2'h0;
      tx_irq_clear = 2'h0;
      cycles(16);
      reset_n = 1'b1;
      cycles(8);
      t_reset;
      t_access;
      t_async_tx;
      t_async_rx;
      t_clocked_rx;
      t_burst;
      t_clocked_tx;
      end_sim;
   end
endmodule

// ==== design/serial_link_engine.sv ====
`timescale 1ns/1ps
module serial_link_engine import serial_mode_pkg::*; (
   // Link clock and system reset
   input  wire logic       link_clk,
   input  wire logic       reset_n,
   // Transmit handshake from system domain
   input  wire logic [7:0] tx_word,
   input  link_cfg_t       tx_cfg,
   input  wire logic       tx_req_tgl,
   output logic            tx_ack_tgl,
   // Receive control and result
   input  link_cfg_t       rx_cfg,
   input  wire logic       rx_enable,
   input  wire logic       burst_req_tgl,
   output logic            burst_ack_tgl,
   output logic [7:0]      rx_word,
   output logic            rx_tgl,
   // Pins
   output logic            txd,
   output logic            tx_sck,
   input  wire logic       rxd,
   input  wire logic       rck_in,
   output logic            rck_out,
   output logic            rck_oe
);
   typedef struct packed {
      logic       rst_s1, rst_s2;
      logic       req_s1, req_s2, req_s3, ack;
      logic       bst_s1, bst_s2, bst_s3, bst_ack;
      logic       rxen_s1, rxen_s2;
      link_cfg_t  cfg_s1, cfg_s2;
      logic       rxd_s1, rxd_s2;
      logic       rck_s1, rck_s2, rck_s3;
      tx_state_t  tx_state;
      logic [11:0] tx_sr;
      logic [3:0] tx_cnt;
      logic       tx_phase, tx_clocked, txd, tx_sck;
      rx_state_t  rx_state;
      logic [7:0] rx_sr, rx_word;
      logic [3:0] rx_cnt;
      logic       rx_tgl;
      logic [3:0] bst_cnt;
      logic       bst_on, rck_out, rck_oe, rise_d1, rise_d2;
   } link_state_t;

   link_state_t r, n;
   logic        rise;
   logic [3:0]  dlen;

   always_comb begin
      n = r;
      n.rst_s1  = reset_n;
      n.rst_s2  = r.rst_s1;
      n.req_s1  = tx_req_tgl;
      n.req_s2  = r.req_s1;
      n.req_s3  = r.req_s2;
      n.bst_s1  = burst_req_tgl;
      n.bst_s2  = r.bst_s1;
      n.bst_s3  = r.bst_s2;
      n.rxen_s1 = rx_enable;
      n.rxen_s2 = r.rxen_s1;
      // Mode bits are quasi-static, so a per-bit level sync is enough
      n.cfg_s1  = rx_cfg;
      n.cfg_s2  = r.cfg_s1;
      n.rxd_s1  = rxd;
      n.rxd_s2  = r.rxd_s1;
      n.rck_s1  = rck_in;
      n.rck_s2  = r.rck_s1;
      n.rck_s3  = r.rck_s2;
      // Own burst edge is delayed to line up with the two-flop path of the data pin
      n.rise_d1 = r.bst_on && !r.rck_out;
      n.rise_d2 = r.rise_d1;
      n.rck_oe  = r.cfg_s2.clocked && r.cfg_s2.rx_int_clock;
      dlen      = r.cfg_s2.eight_bit ? 4'h8 : 4'h7;
      rise      = r.cfg_s2.rx_int_clock ? r.rise_d2 : (r.rck_s2 && !r.rck_s3);

      case (r.tx_state)
         TX_IDLE: begin
            if (r.req_s2 != r.req_s3) begin
               n.tx_state   = TX_SHIFT;
               n.tx_sr      = build_frame(tx_word, tx_cfg);
               n.tx_cnt     = frame_len(tx_cfg);
               n.tx_clocked = tx_cfg.clocked;
               n.tx_phase   = 1'b0;
            end
         end
         TX_SHIFT: begin
            if (r.tx_clocked) begin
               // Data changes on the falling edge, so it is stable at the rising edge
               n.tx_phase = ~r.tx_phase;
               n.tx_sck   = r.tx_phase;
               if (!r.tx_phase) begin
                  n.txd = r.tx_sr[0];
               end else begin
                  n.tx_sr  = {1'b1, r.tx_sr[11:1]};
                  n.tx_cnt = r.tx_cnt - 4'h1;
               end
            end else begin
               n.txd    = r.tx_sr[0];
               n.tx_sr  = {1'b1, r.tx_sr[11:1]};
               n.tx_cnt = r.tx_cnt - 4'h1;
            end
            if (r.tx_cnt == 4'h1 && (!r.tx_clocked || r.tx_phase)) begin
               n.tx_state = TX_IDLE;
               n.ack      = ~r.ack;
            end
         end
         default: n.tx_state = TX_IDLE;
      endcase

      case (r.rx_state)
         RX_IDLE: begin
            n.rx_cnt = 4'h0;
            n.rx_sr  = 8'h00;
            if (r.rxen_s2 && r.cfg_s2.async_mode && !r.rxd_s2) begin
               n.rx_state = RX_ASYNC;
            end else if (r.rxen_s2 && r.cfg_s2.clocked) begin
               n.rx_state = RX_CLOCKED;
            end
         end
         RX_ASYNC: begin
            if (r.rx_cnt < dlen) begin
               n.rx_sr[r.rx_cnt[2:0]] = r.rxd_s2;
            end
            n.rx_cnt = r.rx_cnt + 4'h1;
            // Parity slot is skipped unchecked; the stop slot ends the character
            if (r.rx_cnt == dlen + {3'h0, r.cfg_s2.parity != `PARITY_NONE}) begin
               n.rx_word  = r.rx_sr;
               n.rx_tgl   = ~r.rx_tgl;
               n.rx_state = RX_IDLE;
            end
         end
         RX_CLOCKED: begin
            if (rise) begin
               n.rx_sr  = {r.rx_sr[6:0], r.rxd_s2};
               n.rx_cnt = r.rx_cnt + 4'h1;
               if (r.rx_cnt == `SHIFT_BITS - 4'h1) begin
                  n.rx_word = {r.rx_sr[6:0], r.rxd_s2};
                  n.rx_tgl  = ~r.rx_tgl;
                  n.rx_cnt  = 4'h0;
               end
            end
            if (!r.cfg_s2.clocked) n.rx_state = RX_IDLE;
         end
         default: n.rx_state = RX_IDLE;
      endcase
      if (!r.rxen_s2) n.rx_state = RX_IDLE;
      if (!r.bst_on) begin
         if (r.bst_s2 != r.bst_s3) begin
            n.bst_on  = 1'b1;
            n.bst_cnt = `BURST_CLOCKS;
         end
      end else begin
         n.rck_out = ~r.rck_out;
         if (!r.rck_out) begin
            n.bst_cnt = r.bst_cnt - 4'h1;
            if (r.bst_cnt == 4'h1) begin
               n.bst_on  = 1'b0;
               n.bst_ack = ~r.bst_ack;
            end
         end
      end
      if (!r.rst_s2) begin
         n         = '0;
         n.rst_s1  = reset_n;
         n.rst_s2  = r.rst_s1;
         n.txd     = 1'b1;
         n.tx_sck  = 1'b1;
         n.rck_out = 1'b1;
      end
   end

   always_ff @(posedge link_clk) begin
      r <= n;
   end

   assign tx_ack_tgl    = r.ack;
   assign burst_ack_tgl = r.bst_ack;
   assign rx_word       = r.rx_word;
   assign rx_tgl        = r.rx_tgl;
   assign txd           = r.txd;
   assign tx_sck        = r.tx_sck;
   assign rck_out       = r.rck_out;
   assign rck_oe        = r.rck_oe;

   AST_BURST_EIGHT_CLOCKS: assert property (@(posedge link_clk) disable iff (!r.rst_s2)
      $rose(r.bst_on) |-> ##15 r.bst_on ##1 (!r.bst_on && r.rck_out))
      else $error("receive clock burst is not eight clocks long");
endmodule

// ==== design/serial_mode_control.sv ====
`timescale 1ns/1ps
`include "serial_mode_params.svh"
// Operation
// - Low two mode bits select async or clocked
// - Clocked byte-shift mode exists on channel 0 only
// - Mode registers are 8-bit, byte/bit access, reset zero
// - Buffer-to-shifter move sets flag, then shifts out
// - Clearing receive enable aborts character, no interrupt
// - Async bit 2 picks one or two stops
// - Async bit 3 picks seven or eight bits
// - Async bits 5:4 pick none/zero/odd/even parity
// - Zero parity sends 0, receiver ignores it
// - Async transmit needs bit 7 and low clear-to-send (channel 0: low receive clock pin instead)
// - Clocked bit 2 picks external or internal receive clock
// - Trigger bit outputs exactly eight receive clocks
// - Trigger bit clears itself after the burst
// - Clocked enabled word starts now or after current
// - Disabled word is held, sent when enabled
// - Disable mid-word finishes it, holds next word
// - Clocked characters: eight bits, no parity, MSB first
// - Clocked receive samples rising edge, eight bits complete
module serial_mode_control import serial_mode_pkg::*; (
   // System clock and reset
   input  wire logic            clk,
   input  wire logic            reset_n,
   // Link bit clock
   input  wire logic            link_clk,
   // Mode register access, byte or single bit
   input  wire logic            mode_wr,
   input  wire logic            mode_bit_wr,
   input  wire logic            mode_ch,
   input  wire logic [2:0]      mode_bit_idx,
   input  wire logic            mode_bit_val,
   input  wire logic [7:0]      mode_wr_data,
   output logic [1:0][7:0]      mode_rd_data,
   // Transmit buffer and transmit request flag
   input  wire logic [1:0]      tx_buffer_wr,
   input  wire logic [7:0]      tx_buffer_data,
   output logic [1:0]           tx_buffer_full,
   output logic [1:0]           tx_irq_flag,
   input  wire logic [1:0]      tx_irq_clear,
   // Receive results
   output logic [1:0][7:0]      rx_data,
   output logic [1:0]           rx_done,
   // Serial pins
   output logic [1:0]           txd,
   input  wire logic [1:0]      rxd,
   output logic                 tx_clock_out,
   input  wire logic            clear_to_send_n,
   input  wire logic            rx_clock_pin_in,
   output logic                 rx_clock_pin_out,
   output logic                 rx_clock_pin_oe
);
   typedef struct packed {
      logic [1:0][7:0] mode;
      logic [1:0]      buf_full;
      logic [1:0][7:0] buf_data;
      logic [1:0]      tx_flag;
      logic [1:0]      req_tgl;
      logic [1:0][7:0] word;
      link_cfg_t [1:0] cfg;
      logic [1:0]      cts_s1, cts_s2;
      logic [1:0]      ack_s1, ack_s2;
      logic            burst_tgl, bst_s1, bst_s2, bst_s3;
      logic [1:0]      rxt_s1, rxt_s2, rxt_s3;
      logic [1:0][7:0] rx_data;
      logic [1:0]      rx_done;
   } ctrl_state_t;

   ctrl_state_t     r, n;
   link_cfg_t [1:0] live_cfg;
   link_cfg_t       new_cfg0;
   logic [1:0]      busy, tx_en, rx_on;
   logic            trig_wr;
   logic [1:0]      ack_tgl, rx_tgl, bst_ack_vec, sck_vec, rck_out_vec, rck_oe_vec;
   logic [1:0][7:0] rx_word;

   always_comb begin
      for (int c = 0; c < 2; c++) begin
         live_cfg[c] = decode_mode(r.mode[c], c == 0);
         rx_on[c]    = r.mode[c][`RX_ENABLE_BIT] && (live_cfg[c].clocked || live_cfg[c].async_mode);
      end
   end

   always_comb begin
      n         = r;
      n.rx_done = 2'h0;
      n.cts_s1  = {clear_to_send_n, rx_clock_pin_in};
      n.cts_s2  = r.cts_s1;
      n.ack_s1  = ack_tgl;
      n.ack_s2  = r.ack_s1;
      n.rxt_s1  = rx_tgl;
      n.rxt_s2  = r.rxt_s1;
      n.rxt_s3  = r.rxt_s2;
      n.bst_s1  = bst_ack_vec[0];
      n.bst_s2  = r.bst_s1;
      n.bst_s3  = r.bst_s2;

      // Self-clear first so a software write in the same cycle wins
      if (r.bst_s2 != r.bst_s3) n.mode[0][`RX_BURST_TRIGGER_BIT] = 1'b0;
      if (mode_wr) begin
         n.mode[mode_ch] = mode_wr_data;
      end else if (mode_bit_wr) begin
         n.mode[mode_ch][mode_bit_idx] = mode_bit_val;
      end
      new_cfg0 = decode_mode(n.mode[0], 1'b1);
      trig_wr  = !mode_ch && ((mode_wr && mode_wr_data[`RX_BURST_TRIGGER_BIT])
               || (mode_bit_wr && mode_bit_val && mode_bit_idx == `RX_BURST_TRIGGER_BIT));
      // A trigger while a burst is still in flight is dropped
      if (trig_wr && new_cfg0.clocked && new_cfg0.rx_int_clock && (r.burst_tgl == r.bst_s2)) begin
         n.burst_tgl = ~r.burst_tgl;
      end

      for (int c = 0; c < 2; c++) begin
         busy[c]  = r.req_tgl[c] != r.ack_s2[c];
         tx_en[c] = live_cfg[c].clocked ? r.mode[c][`TX_ENABLE_BIT]
                  : (live_cfg[c].async_mode && r.mode[c][`TX_ENABLE_BIT] && !r.cts_s2[c]);
         if ((r.rxt_s2[c] != r.rxt_s3[c]) && rx_on[c]) begin
            n.rx_data[c] = rx_word[c];
            n.rx_done[c] = 1'b1;
         end
         if (tx_irq_clear[c]) n.tx_flag[c] = 1'b0;
         if (r.buf_full[c] && tx_en[c] && !busy[c]) begin
            n.word[c]     = r.buf_data[c];
            n.cfg[c]      = live_cfg[c];
            n.req_tgl[c]  = ~r.req_tgl[c];
            n.buf_full[c] = 1'b0;
            n.tx_flag[c]  = 1'b1;
         end
         if (tx_buffer_wr[c]) begin
            n.buf_data[c] = tx_buffer_data;
            n.buf_full[c] = 1'b1;
         end
      end
      if (!reset_n) begin
         n      = '0;
         n.mode = {`MODE_RESET, `MODE_RESET};
      end
   end

   always_ff @(posedge clk) begin
      r <= n;
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : chan
         serial_link_engine u_engine (
            .link_clk      (link_clk),
            .reset_n       (reset_n),
            .tx_word       (r.word[g]),
            .tx_cfg        (r.cfg[g]),
            .tx_req_tgl    (r.req_tgl[g]),
            .tx_ack_tgl    (ack_tgl[g]),
            .rx_cfg        (live_cfg[g]),
            .rx_enable     (rx_on[g]),
            .burst_req_tgl ((g == 0) ? r.burst_tgl : 1'b0),
            .burst_ack_tgl (bst_ack_vec[g]),
            .rx_word       (rx_word[g]),
            .rx_tgl        (rx_tgl[g]),
            .txd           (txd[g]),
            .tx_sck        (sck_vec[g]),
            .rxd           (rxd[g]),
            .rck_in        ((g == 0) ? rx_clock_pin_in : 1'b1),
            .rck_out       (rck_out_vec[g]),
            .rck_oe        (rck_oe_vec[g])
         );
      end
   endgenerate

   assign mode_rd_data     = r.mode;
   assign tx_buffer_full   = r.buf_full;
   assign tx_irq_flag      = r.tx_flag;
   assign rx_data          = r.rx_data;
   assign rx_done          = r.rx_done;
   assign tx_clock_out     = sck_vec[0];
   assign rx_clock_pin_out = rck_out_vec[0];
   assign rx_clock_pin_oe  = rck_oe_vec[0];

   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   AST_MODE_RESET_ZERO: assert property (disable iff (1'b0)
      !reset_n |=> (r.mode[0] == 8'h00 && r.mode[1] == 8'h00 && !r.tx_flag[0]))
      else $error("mode registers not zero after reset");
   AST_FLAG_WITH_LOAD: assert property (
      (r.buf_full[0] && tx_en[0] && !busy[0]) |=> (r.tx_flag[0] && !busy[0] == 1'b0))
      else $error("buffer move did not set the transmit flag");
   AST_CTS_BLOCKS_TX: assert property (
      (live_cfg[1].async_mode && r.cts_s2[1]) |=> $stable(r.req_tgl[1]))
      else $error("async transmit started with clear-to-send high");
   AST_CH1_NO_CLOCKED: assert property (
      (r.mode[1][1:0] == `MODE_CLOCKED && r.buf_full[1]) |=> $stable(r.req_tgl[1]))
      else $error("channel 1 transmitted in clocked mode");
   AST_HOLD_WHILE_DISABLED: assert property (
      (live_cfg[0].clocked && !r.mode[0][`TX_ENABLE_BIT]) |=> $stable(r.req_tgl[0]))
      else $error("clocked word sent while transmit disabled");
   AST_START_WHEN_ENABLED: assert property (
      (live_cfg[0].clocked && r.mode[0][`TX_ENABLE_BIT] && r.buf_full[0] && !busy[0])
      |=> ($changed(r.req_tgl[0]) && !r.buf_full[0]) or (r.buf_full[0] && $past(tx_buffer_wr[0])))
      else $error("enabled clocked word did not start");
   AST_NO_DONE_WHEN_DISABLED: assert property (
      !rx_on[0] |=> !r.rx_done[0])
      else $error("reception complete raised while disabled");
   AST_BURST_SELF_CLEAR: assert property (
      (r.bst_s2 != r.bst_s3 && !mode_wr && !mode_bit_wr) |=> !r.mode[0][`RX_BURST_TRIGGER_BIT])
      else $error("trigger bit not cleared after burst");
   AST_EXT_CLOCK_NO_BURST: assert property (
      (!new_cfg0.rx_int_clock) |=> $stable(r.burst_tgl))
      else $error("burst started with external receive clock");
endmodule

// ==== design/serial_mode_params.svh ====
`ifndef SERIAL_MODE_PARAMS_SVH
`define SERIAL_MODE_PARAMS_SVH

// Mode register field positions
`define MODE_SEL_LO_BIT        0
`define MODE_SEL_HI_BIT        1
`define STOP_BITS_SEL_BIT      2
`define RX_CLOCK_SOURCE_BIT    2
`define CHAR_LENGTH_SEL_BIT    3
`define RX_BURST_TRIGGER_BIT   3
`define PARITY_SEL_LO_BIT      4
`define PARITY_SEL_HI_BIT      5
`define RX_ENABLE_BIT          6
`define TX_ENABLE_BIT          7

// Mode register values
`define MODE_RESET             8'h00
`define MODE_CLOCKED           2'h0
`define MODE_ASYNC             2'h1
`define PARITY_NONE            2'h0
`define PARITY_ZERO            2'h1
`define PARITY_ODD             2'h2
`define PARITY_EVEN            2'h3

// Counts
`define SHIFT_BITS             4'h8
`define BURST_CLOCKS           4'h8
`define FRAME_BITS             12

`endif

// ==== design/serial_mode_pkg.sv ====
package serial_mode_pkg;
`include "serial_mode_params.svh"

   typedef struct packed {
      logic       clocked;
      logic       async_mode;
      logic       two_stop;
      logic       eight_bit;
      logic [1:0] parity;
      logic       rx_int_clock;
   } link_cfg_t;

   typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;
   typedef enum logic [1:0] {RX_IDLE, RX_ASYNC, RX_CLOCKED} rx_state_t;

   function automatic link_cfg_t decode_mode(input logic [7:0] m, input logic clocked_ok);
      link_cfg_t c;
      c.clocked      = clocked_ok && (m[`MODE_SEL_HI_BIT:`MODE_SEL_LO_BIT] == `MODE_CLOCKED);
      c.async_mode   = (m[`MODE_SEL_HI_BIT:`MODE_SEL_LO_BIT] == `MODE_ASYNC);
      c.two_stop     = m[`STOP_BITS_SEL_BIT];
      c.eight_bit    = m[`CHAR_LENGTH_SEL_BIT];
      c.parity       = m[`PARITY_SEL_HI_BIT:`PARITY_SEL_LO_BIT];
      c.rx_int_clock = m[`RX_CLOCK_SOURCE_BIT];
      return c;
   endfunction

   // Frame is shifted out from bit 0; unused upper bits idle at 1
   function automatic logic [11:0] build_frame(input logic [7:0] d, input link_cfg_t c);
      logic [11:0] f;
      logic [7:0]  de;
      int          pos;
      f   = 12'hFFF;
      de  = c.eight_bit ? d : {1'b0, d[6:0]};
      pos = 1;
      if (c.clocked) begin
         for (int i = 0; i < 8; i++) f[i] = d[7 - i];
      end else begin
         f[0] = 1'b0;
         for (int i = 0; i < 8; i++) begin
            if (i < 7 || c.eight_bit) begin
               f[pos] = d[i];
               pos++;
            end
         end
         case (c.parity)
            `PARITY_ODD:  f[pos] = ~^de;
            `PARITY_EVEN: f[pos] = ^de;
            `PARITY_ZERO: f[pos] = 1'b0;
            default:      f[pos] = 1'b1;
         endcase
      end
      return f;
   endfunction

   function automatic logic [3:0] frame_len(input link_cfg_t c);
      logic [3:0] n;
      if (c.clocked) begin
         n = `SHIFT_BITS;
      end else begin
         n = 4'h1 + (c.eight_bit ? 4'h8 : 4'h7) + {3'h0, c.parity != `PARITY_NONE}
           + (c.two_stop ? 4'h2 : 4'h1);
      end
      return n;
   endfunction

endpackage
